// File: hw/mrr_pkg.sv
// Purpose: constants for the measurement readout register bank
// Assumes: register port driven by the serial control slave logic
// Notes:   Operation list follows
// Operation
// - supply max low byte sits in an 8-bit read-only register that resets to zero.
// - the secondary supply is measured when the configuration mode bit is one, else the battery.
// - battery code times 1.49 gives millivolts; the raw 12-bit code is kept as measured.
// - secondary code times 1.01 gives millivolts; the raw 12-bit code is kept as measured.
// - a result pair is not updated while one of its registers is addressed, except that supply_max_clear still zeroes the supply max.
// - reading a high part copies the matching low byte into a shadow register.
// - reading a low byte returns the shadow captured at the previous high read.
// - temperature high nibble sits in bits 3:0, bits 7:4 read zero, reset zero.
// - temperature low byte sits in an 8-bit read-only register resetting to zero.
// - temperature is a 12-bit two's complement code, 40 + (code + 2) / 6.04236 degrees.
// - the slow flag is set while the switch is enabled and its pin is still low.
`default_nettype none
package mrr_pkg;
    localparam int         MEAS_W          = 12;
    localparam logic [7:0] OFS_SUPPLY_MAX_HI = 8'h1F;
    localparam logic [7:0] OFS_SUPPLY_MAX_LO = 8'h20;
    localparam logic [7:0] OFS_TEMP_HI       = 8'h21;
    localparam logic [7:0] OFS_TEMP_LO       = 8'h22;
    localparam logic [7:0] OFS_SW_STATUS     = 8'h23;
    localparam logic [7:0] RST_BYTE          = 8'h00;
    localparam logic [3:0] RESERVED_NIBBLE   = 4'h0;
    localparam logic [6:0] RESERVED_SW_BITS  = 7'h00;
    localparam int         HI_LSB            = 8;
    localparam int         HI_MSB            = 11;
    localparam int         LO_MSB            = 7;
endpackage : mrr_pkg
`default_nettype wire

// File: hw/mrr_readout.sv
// Purpose: read-only measurement result registers with coherent reads
// Assumes: reg_rd is a one-cycle read strobe, reg_sel marks the pointer
// Notes:   read data appears one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module mrr_readout #(
    parameter int MEAS_W = mrr_pkg::MEAS_W
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // register port from serial slave
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_sel,
    input  wire logic              reg_rd,
    output var  logic [7:0]        rd_data_q,
    output var  logic              rd_valid_q,
    // supply measurement
    input  wire logic              supply_configuration_mode_bit,
    input  wire logic [MEAS_W-1:0] secondary_supply_code,
    input  wire logic [MEAS_W-1:0] battery_supply_code,
    input  wire logic              supply_valid,
    input  wire logic              supply_max_clear,
    // temperature measurement
    input  wire logic [MEAS_W-1:0] temp_code,
    input  wire logic              temp_valid,
    // switched output monitor
    input  wire logic              switched_output_en,
    input  wire logic              switched_output_low
);
    localparam logic [7:0] A_SHI = mrr_pkg::OFS_SUPPLY_MAX_HI;
    localparam logic [7:0] A_SLO = mrr_pkg::OFS_SUPPLY_MAX_LO;
    localparam logic [7:0] A_THI = mrr_pkg::OFS_TEMP_HI;
    localparam logic [7:0] A_TLO = mrr_pkg::OFS_TEMP_LO;
    localparam logic [7:0] A_SW  = mrr_pkg::OFS_SW_STATUS;
    localparam int         HL    = mrr_pkg::HI_LSB;
    localparam int         HM    = mrr_pkg::HI_MSB;
    localparam int         LM    = mrr_pkg::LO_MSB;

    // the nibble plus byte layout only fits a 12-bit code
    if (MEAS_W != mrr_pkg::MEAS_W) begin : g_bad_width
        $error("mrr_readout: MEAS_W must be 12");
    end

    logic [MEAS_W-1:0] supply_max_q;
    logic [MEAS_W-1:0] temp_q;
    logic [MEAS_W-1:0] temp_pend_q;
    logic              temp_pend_vld_q;
    logic [7:0]        supply_shadow_q;
    logic [7:0]        temp_shadow_q;
    logic              slow_turn_on_flag_q;
    logic [MEAS_W-1:0] supply_sample;
    logic              supply_inhibit;
    logic              temp_inhibit;
    logic              rd_shi;
    logic              rd_slo;
    logic              rd_thi;
    logic              rd_tlo;
    logic              rd_sw;

    // source select and address decode
    assign supply_sample  = supply_configuration_mode_bit ?
                            secondary_supply_code :
                            battery_supply_code;
    assign supply_inhibit = reg_sel &&
                            (reg_addr == A_SHI || reg_addr == A_SLO);
    assign temp_inhibit   = reg_sel &&
                            (reg_addr == A_THI || reg_addr == A_TLO);
    assign rd_shi = reg_rd && reg_addr == A_SHI;
    assign rd_slo = reg_rd && reg_addr == A_SLO;
    assign rd_thi = reg_rd && reg_addr == A_THI;
    assign rd_tlo = reg_rd && reg_addr == A_TLO;
    assign rd_sw  = reg_rd && reg_addr == A_SW;

    // max supply record, frozen while addressed except by supply_max_clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            supply_max_q <= '0;
        end else if (supply_max_clear) begin
            supply_max_q <= '0;
        end else if (supply_valid && !supply_inhibit &&
                     supply_sample > supply_max_q) begin
            supply_max_q <= supply_sample;
        end
    end

    // latest temperature; a sample seen while addressed waits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temp_q          <= '0;
            temp_pend_q     <= '0;
            temp_pend_vld_q <= 1'b0;
        end else if (temp_inhibit) begin
            if (temp_valid) begin
                temp_pend_q     <= temp_code;
                temp_pend_vld_q <= 1'b1;
            end
        end else if (temp_valid) begin
            temp_q          <= temp_code;
            temp_pend_vld_q <= 1'b0;
        end else if (temp_pend_vld_q) begin
            temp_q          <= temp_pend_q;
            temp_pend_vld_q <= 1'b0;
        end
    end

    // low byte shadows, loaded on a high part read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            supply_shadow_q <= mrr_pkg::RST_BYTE;
            temp_shadow_q   <= mrr_pkg::RST_BYTE;
        end else begin
            if (rd_shi) begin
                supply_shadow_q <= supply_max_q[LM:0];
            end
            if (rd_thi) begin
                temp_shadow_q <= temp_q[LM:0];
            end
        end
    end

    // slow turn-on status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slow_turn_on_flag_q <= 1'b0;
        end else begin
            slow_turn_on_flag_q <= switched_output_en &&
                                   switched_output_low;
        end
    end

    // read data mux; writes are not decoded at all
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_q  <= mrr_pkg::RST_BYTE;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd;
            if (rd_shi) begin
                rd_data_q <= {mrr_pkg::RESERVED_NIBBLE,
                              supply_max_q[HM:HL]};
            end else if (rd_slo) begin
                rd_data_q <= supply_shadow_q;
            end else if (rd_thi) begin
                rd_data_q <= {mrr_pkg::RESERVED_NIBBLE,
                              temp_q[HM:HL]};
            end else if (rd_tlo) begin
                rd_data_q <= temp_shadow_q;
            end else if (rd_sw) begin
                rd_data_q <= {mrr_pkg::RESERVED_SW_BITS,
                              slow_turn_on_flag_q};
            end else if (reg_rd) begin
                rd_data_q <= mrr_pkg::RST_BYTE;           // unmapped
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_temp_hi_read;
        reg_rd && reg_addr == A_THI;
    endsequence
    sequence s_temp_lo_read;
        reg_rd && reg_addr == A_TLO;
    endsequence

    property p_max_grow;
        supply_valid && !supply_inhibit && !supply_max_clear &&
        supply_sample > supply_max_q |=> supply_max_q == $past(supply_sample);
    endproperty
    a_max_grow: assert property (p_max_grow)
        else $error("max record missed a larger sample");

    property p_max_mono;
        !supply_max_clear |=> supply_max_q >= $past(supply_max_q);
    endproperty
    a_max_mono: assert property (p_max_mono)
        else $error("max record fell without a clear");

    property p_sec_sel;
        supply_valid && supply_configuration_mode_bit && !supply_inhibit &&
        !supply_max_clear && secondary_supply_code > supply_max_q
        |=> supply_max_q == $past(secondary_supply_code);
    endproperty
    a_sec_sel: assert property (p_sec_sel)
        else $error("secondary supply not selected");

    property p_inhibit;
        supply_inhibit && !supply_max_clear |=> $stable(supply_max_q);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("max record changed while addressed");

    property p_temp_hold;
        temp_inhibit |=> $stable(temp_q);
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("temperature changed while addressed");

    property p_shadow;
        s_temp_hi_read |=> temp_shadow_q == $past(temp_q[LM:0]);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("shadow not loaded on high read");

    property p_coherent;
        s_temp_hi_read ##1 s_temp_lo_read
        |=> rd_data_q == $past(temp_q[LM:0], 2);
    endproperty
    a_coherent: assert property (p_coherent)
        else $error("low read not from shadow");

    property p_hi_nibble;
        s_temp_hi_read |=> rd_data_q == {mrr_pkg::RESERVED_NIBBLE,
                                         $past(temp_q[HM:HL])};
    endproperty
    a_hi_nibble: assert property (p_hi_nibble)
        else $error("temperature high nibble wrong");

    property p_temp_take;
        temp_valid && !temp_inhibit |=> temp_q == $past(temp_code);
    endproperty
    a_temp_take: assert property (p_temp_take)
        else $error("temperature sample not taken");

    property p_slow;
        switched_output_en && switched_output_low
        |=> rd_sw |=> rd_data_q == {mrr_pkg::RESERVED_SW_BITS, 1'b1};
    endproperty
    a_slow: assert property (p_slow)
        else $error("slow flag not reported");

    // supply pair read phases
    sequence s_sup_hi_read;
        reg_rd && reg_addr == A_SHI;
    endsequence
    sequence s_sup_lo_read;
        reg_rd && reg_addr == A_SLO;
    endsequence

    // supply pair coherence
    property p_sup_shadow;
        s_sup_hi_read |=> supply_shadow_q == $past(supply_max_q[LM:0]);
    endproperty
    a_sup_shadow: assert property (p_sup_shadow)
        else $error("supply shadow not loaded on high read");

    property p_sup_coherent;
        s_sup_hi_read ##1 s_sup_lo_read
        |=> rd_data_q == $past(supply_max_q[LM:0], 2);
    endproperty
    a_sup_coherent: assert property (p_sup_coherent)
        else $error("supply low read not from shadow");

    property p_sup_hi_nibble;
        s_sup_hi_read |=> rd_data_q == {mrr_pkg::RESERVED_NIBBLE,
                                        $past(supply_max_q[HM:HL])};
    endproperty
    a_sup_hi_nibble: assert property (p_sup_hi_nibble)
        else $error("supply high nibble wrong");

    // record upkeep
    property p_sup_keep;
        supply_valid && !supply_max_clear && supply_sample <= supply_max_q
        |=> $stable(supply_max_q);
    endproperty
    a_sup_keep: assert property (p_sup_keep)
        else $error("max record replaced by a smaller sample");

    property p_clear;
        supply_max_clear |=> supply_max_q == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("max record not cleared");

    property p_temp_apply;
        temp_pend_vld_q && !temp_inhibit && !temp_valid
        |=> temp_q == $past(temp_pend_q) && !temp_pend_vld_q;
    endproperty
    a_temp_apply: assert property (p_temp_apply)
        else $error("held temperature sample not applied");

    // status byte layout
    property p_sw_reserved;
        rd_sw |=> rd_data_q == {mrr_pkg::RESERVED_SW_BITS,
                                $past(slow_turn_on_flag_q)};
    endproperty
    a_sw_reserved: assert property (p_sw_reserved)
        else $error("status byte layout wrong");

    property p_slow_off;
        !(switched_output_en && switched_output_low)
        |=> rd_sw |=> rd_data_q == mrr_pkg::RST_BYTE;
    endproperty
    a_slow_off: assert property (p_slow_off)
        else $error("slow flag reported with the switch settled");

    // reset clears every record and the read port
    property p_reset;
        disable iff (1'b0)
        rst |=> rd_data_q == mrr_pkg::RST_BYTE && !rd_valid_q &&
                supply_max_q == '0 && temp_q == '0 &&
                !slow_turn_on_flag_q;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state not cleared by reset");

endmodule : mrr_readout
`default_nettype wire

// File: verification/mrr_host_model.sv
// Purpose: host side model reading the readout registers
// Assumes: one read in flight, strobe one cycle wide except in read_pair, which holds it high for two reads
// Notes:   a released pointer shows the inverse of its last address
`timescale 1ns/10ps
`default_nettype none
module mrr_host_model (
    // clock
    input  wire logic       sys_clk,
    // register port toward the bank
    output var  logic [7:0] reg_addr,
    output var  logic       reg_sel,
    output var  logic       reg_rd,
    input  wire logic [7:0] rd_data_q,
    input  wire logic       rd_valid_q
);
    // idle pointer; there is no write path at all
    initial begin
        reg_addr = 8'h00;
        reg_sel  = 1'b0;
        reg_rd   = 1'b0;
    end
    // drop the pointer and scramble the stale address
    task automatic release_bus();
        @(posedge sys_clk);
        reg_sel  <= 1'b0;
        reg_addr <= ~reg_addr;
    endtask : release_bus
    // one read; keep leaves the pointer on the pair for a low read
    task automatic read(input logic [7:0] a, input bit keep,
                        output logic [7:0] d, output bit ok);
        ok = 1'b0;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_sel  <= 1'b1;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge sys_clk);
            ok = (rd_valid_q === 1'b1);
        end
        d = rd_data_q;
        if (!keep) release_bus();
    endtask : read
    // high then low read on consecutive edges, pointer held between
    task automatic read_pair(input logic [7:0] a, output logic [7:0] dh,
                             output logic [7:0] dl, output bit ok);
        ok = 1'b0;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_sel  <= 1'b1;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_addr <= a + 8'h01;
        @(negedge sys_clk);
        dh = rd_data_q;
        ok = (rd_valid_q === 1'b1);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        dl = rd_data_q;
        ok = ok && (rd_valid_q === 1'b1);
        release_bus();
    endtask : read_pair
endmodule : mrr_host_model
`default_nettype wire

// File: verification/mrr_readout_tb.sv
// Purpose: self-checking bench for the readout register bank
// Assumes: host model owns the register port
// Notes:   samples are one-cycle pulses driven at the rising edge
`timescale 1ns/10ps
`default_nettype none
module mrr_readout_tb;
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic [7:0]  reg_addr, rd_data_q;
    logic        reg_sel, reg_rd, rd_valid_q;
    logic        supply_configuration_mode_bit = 1'b0;
    logic [11:0] secondary_supply_code = 12'h000;
    logic [11:0] battery_supply_code = 12'h000, temp_code = 12'h000;
    logic        supply_valid = 1'b0, supply_max_clear = 1'b0;
    logic        temp_valid = 1'b0;
    logic        switched_output_en = 1'b0, switched_output_low = 1'b0;
    int          fails = 0, check_count = 0;
    // bank and host
    mrr_readout u_dut (.sys_clk, .rst, .reg_addr, .reg_sel, .reg_rd,
        .rd_data_q, .rd_valid_q, .supply_configuration_mode_bit,
        .secondary_supply_code, .battery_supply_code, .supply_valid,
        .supply_max_clear, .temp_code, .temp_valid, .switched_output_en,
        .switched_output_low);
    mrr_host_model u_host (.sys_clk, .reg_addr, .reg_sel, .reg_rd,
        .rd_data_q, .rd_valid_q);
    // 25 MHz clock
    initial forever #20 sys_clk = ~sys_clk;
    // verdict and end of run
    task automatic summarize();
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // read one register and compare
    task automatic rd(input logic [7:0] a, input bit keep,
                      input logic [7:0] e, input string n);
        logic [7:0] d;
        bit         ok;
        u_host.read(a, keep, d, ok);
        check_count++;
        if (!ok) begin
            fails++;
            $display("MISMATCH %s_valid expected 1 seen 0", n);
            summarize();
        end else if (d !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, d);
        end
    endtask : rd
    // back to back high then low read of one pair
    task automatic rd_pair(input logic [7:0] a, input logic [7:0] eh,
                           input logic [7:0] el, input string n);
        logic [7:0] dh;
        logic [7:0] dl;
        bit         ok;
        u_host.read_pair(a, dh, dl, ok);
        check_count++;
        if (!ok) begin
            fails++;
            $display("MISMATCH %s_valid expected 1 seen 0", n);
            summarize();
        end else if ({dh, dl} !== {eh, el}) begin
            fails++;
            $display("MISMATCH %s expected %h%h seen %h%h", n, eh, el, dh, dl);
        end
    endtask : rd_pair
    // one supply sample pulse, optionally preceded by a clear
    task automatic supply(input logic m, input logic [11:0] s,
                          input logic [11:0] b, input bit clr);
        @(posedge sys_clk);
        supply_max_clear <= clr;
        supply_configuration_mode_bit <= m;
        secondary_supply_code <= s;
        battery_supply_code <= b;
        if (clr) begin
            @(posedge sys_clk);
            supply_max_clear <= 1'b0;
        end
        supply_valid <= 1'b1;
        @(posedge sys_clk);
        supply_valid <= 1'b0;
    endtask : supply
    // one temperature sample pulse
    task automatic temp(input logic [11:0] t);
        @(posedge sys_clk);
        temp_code <= t;
        temp_valid <= 1'b1;
        @(posedge sys_clk);
        temp_valid <= 1'b0;
    endtask : temp
    // every register and an unmapped one read zero after reset
    task automatic t_reset();
        for (int a = 8'h1F; a <= 8'h24; a++) begin
            rd(a[7:0], 0, 8'h00, "reset_byte");
        end
    endtask : t_reset
    // source select, max tracking and clear
    task automatic t_supply();
        supply(0, 12'hAAA, 12'h345, 0);
        rd(8'h1F, 1, 8'h03, "max_hi");
        rd(8'h20, 0, 8'h45, "max_lo");
        supply(0, 12'hFFF, 12'h100, 0);
        rd(8'h1F, 1, 8'h03, "max_hi_kept");
        rd(8'h20, 0, 8'h45, "max_lo_kept");
        supply(1, 12'h9AB, 12'hFFF, 0);
        rd(8'h1F, 1, 8'h09, "max_hi_sec");
        rd(8'h20, 0, 8'hAB, "max_lo_sec");
        supply(0, 12'h000, 12'h123, 1);
        rd(8'h1F, 1, 8'h01, "max_hi_clr");
        rd(8'h20, 0, 8'h23, "max_lo_clr");
        rd_pair(8'h1F, 8'h01, 8'h23, "max_pair");
    endtask : t_supply
    // a sample arriving while the pair is addressed is dropped
    task automatic t_inhibit();
        rd(8'h1F, 1, 8'h01, "inh_hi");
        supply(0, 12'h000, 12'h7FE, 0);
        rd(8'h20, 0, 8'h23, "inh_lo");
        rd(8'h1F, 0, 8'h01, "inh_after");
    endtask : t_inhibit
    // shadow capture, deferred temperature update, negative code
    task automatic t_temp();
        temp(12'hF8C);
        rd(8'h21, 1, 8'h0F, "temp_hi");
        temp(12'h3D5);
        rd(8'h22, 0, 8'h8C, "temp_lo");
        rd(8'h21, 1, 8'h03, "temp_hi_late");
        rd(8'h22, 0, 8'hD5, "temp_lo_late");
        temp(12'h111);
        rd(8'h22, 0, 8'hD5, "temp_lo_shadow");
        rd(8'h21, 1, 8'h01, "temp_hi_new");
        rd(8'h22, 0, 8'h11, "temp_lo_new");
        temp(12'h2B7);
        rd_pair(8'h21, 8'h02, 8'hB7, "temp_pair");
    endtask : t_temp
    // slow turn-on flag follows enable and low pin
    task automatic t_switch();
        switched_output_en <= 1'b1;
        switched_output_low <= 1'b1;
        rd(8'h23, 0, 8'h01, "sw_slow");
        switched_output_low <= 1'b0;
        rd(8'h23, 0, 8'h00, "sw_done");
        switched_output_en <= 1'b0;
        switched_output_low <= 1'b1;
        rd(8'h23, 0, 8'h00, "sw_off");
    endtask : t_switch
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_supply();
        t_inhibit();
        t_temp();
        t_switch();
        summarize();
    end
endmodule : mrr_readout_tb
`default_nettype wire
